// ==== design/ahem_defs.svh ====
`ifndef AHEM_DEFS_SVH
`define AHEM_DEFS_SVH
// Host side offsets
`define AHEM_H_DATA0 3'h0
`define AHEM_H_DATA3 3'h3
`define AHEM_H_CMD_STAT 3'h4
`define AHEM_H_BCTRL 3'h5
// Controller side offsets
`define AHEM_C_H2C0 4'h8
`define AHEM_C_H2C3 4'hb
`define AHEM_C_C2H0 4'h0
`define AHEM_C_C2H3 4'h3
`define AHEM_C_STATUS 4'h4
`define AHEM_C_BCTRL 4'h5
// Status bit positions and the firmware-owned bits
`define AHEM_ST_OBF_BIT 0
`define AHEM_ST_IBF_BIT 1
`define AHEM_ST_CMD_BIT 3
`define AHEM_ST_SOFT_MASK 8'hf4
`define AHEM_BCTRL_MODE_BIT 0
`define AHEM_BYTE_RST 8'h00
`define AHEM_FIFO_DEPTH 16
`endif

// ==== design/ahem_pkg.sv ====
package ahem_pkg;
  // Host-side access: write/read strobes, byte offset, write data
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ahem_host_req_s;
  // Controller-side access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ahem_ctrl_req_s;
  // Read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ahem_rsp_s;
  // Queued host write
  typedef struct packed {
    logic is_cmd;
    logic [1:0] idx;
    logic [7:0] data;
  } ahem_entry_s;
  typedef enum logic {AHEM_LEGACY, AHEM_FOUR_BYTE} ahem_mode_e;
endpackage

// ==== design/ahem_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ahem_defs.svh"

module ahem_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = `AHEM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic rdy_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  // Ready is registered from the next count, so the port comes from a flop
  assign in_ready_o = rdy_q;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rp_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      wp_q <= push ? wp_q + 1'b1 : wp_q;
      rp_q <= pop ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
  a_fifo_ready_full: assert property (@(posedge clk_i) disable iff (!resetn_i)
    in_ready_o == (cnt_q != (AW+1)'(DEPTH))) else $error("fifo ready disagrees with count");
endmodule

////////////////////////////////////////////////////////////////////////////////

module ahem_chan
  import ahem_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host side
  input wire ahem_host_req_s host_i,
  output logic host_wr_ready_o,
  output ahem_rsp_s host_rsp_o,
  output logic host_output_empty_irq_o,
  // Controller side
  input wire ahem_ctrl_req_s ctrl_i,
  output ahem_rsp_s ctrl_rsp_o,
  output logic input_full_irq_o,
  output logic output_drained_irq_o,
  output logic combined_irq_o,
  // Status
  output logic idle_o
);
  ahem_mode_e mode_q;
  logic input_buffer_full_q;
  logic output_buffer_full_q;
  logic cmd_flag_q;
  logic [7:0] soft_q;
  logic [7:0] h2c_q [4];
  logic [7:0] c2h_q [4];
  ahem_rsp_s host_rsp_q;
  ahem_rsp_s ctrl_rsp_q;
  logic in_full_irq_q;
  logic drained_irq_q;
  logic host_irq_q;
  logic comb_irq_q;
  logic idle_q;

  //////////////////////////////////////////////////////////////////////////////
  // Host writes queue here; a held byte 0 stalls the queue instead of
  // being overwritten, so the host sees back-pressure, not lost data.
  wire four = (mode_q == AHEM_FOUR_BYTE);
  wire h_is_cmd = (host_i.addr == `AHEM_H_CMD_STAT);
  wire h_is_data = (host_i.addr <= `AHEM_H_DATA3);
  wire h_data_ok = h_is_data && (four || host_i.addr == `AHEM_H_DATA0);
  wire q_ready;
  wire q_valid;
  ahem_entry_s q_in;
  ahem_entry_s q_out;
  assign q_in.is_cmd = h_is_cmd;
  assign q_in.idx = h_is_cmd ? 2'h0 : host_i.addr[1:0];
  assign q_in.data = host_i.wdata;
  wire q_push = host_i.wr && (h_is_cmd || h_data_ok);
  wire q_byte0 = (q_out.idx == 2'h0);
  wire q_pop = q_valid && !(input_buffer_full_q && q_byte0);

  ahem_fifo #(.WIDTH($bits(ahem_entry_s)), .DEPTH(`AHEM_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(q_push),
    .in_ready_o(q_ready),
    .in_data_i(q_in),
    .out_valid_o(q_valid),
    .out_ready_i(q_pop),
    .out_data_o(q_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Flag updates: a set in the same cycle as a clear wins
  wire ibf_set = q_pop && q_byte0;
  wire ibf_clr = ctrl_i.rd && (ctrl_i.addr == `AHEM_C_H2C0);
  wire ibf_d = ibf_set || (input_buffer_full_q && !ibf_clr);
  wire obf_set = ctrl_i.wr && (ctrl_i.addr == `AHEM_C_C2H0);
  wire obf_clr = host_i.rd && (host_i.addr == `AHEM_H_DATA0);
  wire obf_d = obf_set || (output_buffer_full_q && !obf_clr);
  wire ibf_rise = ibf_d && !input_buffer_full_q;
  wire obf_fall = output_buffer_full_q && !obf_d;
  wire c_st_wr = ctrl_i.wr && (ctrl_i.addr == `AHEM_C_STATUS);
  wire c_mode_wr = ctrl_i.wr && (ctrl_i.addr == `AHEM_C_BCTRL);
  wire c_c2h_wr = ctrl_i.wr && (ctrl_i.addr <= `AHEM_C_C2H3);
  wire any_acc = host_i.wr || host_i.rd || ctrl_i.wr || ctrl_i.rd;

  // Event bits live in the status byte; ibf_rise and obf_fall also drive the interrupts
  wire [7:0] status = (soft_q & `AHEM_ST_SOFT_MASK)
    | (8'h01 << `AHEM_ST_OBF_BIT) & {8{output_buffer_full_q}}
    | (8'h01 << `AHEM_ST_IBF_BIT) & {8{input_buffer_full_q}}
    | (8'h01 << `AHEM_ST_CMD_BIT) & {8{cmd_flag_q}};
  wire [7:0] bctrl = {7'h00, four};

  //////////////////////////////////////////////////////////////////////////////
  // Read data selection; upper bytes read zero on the host side in legacy mode
  wire [7:0] h_data_rd = (four || host_i.addr == `AHEM_H_DATA0) ?
    c2h_q[host_i.addr[1:0]] : `AHEM_BYTE_RST;
  wire [7:0] h_rdata = h_is_data ? h_data_rd :
    h_is_cmd ? status :
    (host_i.addr == `AHEM_H_BCTRL) ? bctrl : 8'h00;
  wire c_h2c = (ctrl_i.addr >= `AHEM_C_H2C0) && (ctrl_i.addr <= `AHEM_C_H2C3);
  wire [7:0] c_rdata = c_h2c ? h2c_q[ctrl_i.addr[1:0]] :
    (ctrl_i.addr <= `AHEM_C_C2H3) ? c2h_q[ctrl_i.addr[1:0]] :
    (ctrl_i.addr == `AHEM_C_STATUS) ? status :
    (ctrl_i.addr == `AHEM_C_BCTRL) ? bctrl : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Per-byte data registers
  for (genvar b = 0; b < 4; b++) begin : g_byte
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        h2c_q[b] <= `AHEM_BYTE_RST;
        c2h_q[b] <= `AHEM_BYTE_RST;
      end else begin
        if (q_pop && q_out.idx == 2'(b)) begin
          h2c_q[b] <= q_out.data;
        end
        if (c_c2h_wr && ctrl_i.addr[1:0] == 2'(b)) begin
          c2h_q[b] <= ctrl_i.wdata;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= AHEM_LEGACY;
      input_buffer_full_q <= 1'b0;
      output_buffer_full_q <= 1'b0;
      cmd_flag_q <= 1'b0;
      soft_q <= 8'h00;
    end else begin
      mode_q <= c_mode_wr ? ahem_mode_e'(ctrl_i.wdata[`AHEM_BCTRL_MODE_BIT]) : mode_q;
      input_buffer_full_q <= ibf_d;
      output_buffer_full_q <= obf_d;
      cmd_flag_q <= ibf_set ? q_out.is_cmd : cmd_flag_q;
      soft_q <= c_st_wr ? (ctrl_i.wdata & `AHEM_ST_SOFT_MASK) : soft_q;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_rsp_q <= '0;
      ctrl_rsp_q <= '0;
      in_full_irq_q <= 1'b0;
      drained_irq_q <= 1'b0;
      host_irq_q <= 1'b0;
      comb_irq_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      host_rsp_q <= '{valid: host_i.rd, data: host_i.rd ? h_rdata : 8'h00};
      ctrl_rsp_q <= '{valid: ctrl_i.rd, data: ctrl_i.rd ? c_rdata : 8'h00};
      in_full_irq_q <= ibf_rise;
      drained_irq_q <= obf_fall;
      host_irq_q <= obf_fall;
      comb_irq_q <= ibf_rise || obf_fall;
      idle_q <= !any_acc;
    end
  end

  assign host_wr_ready_o = q_ready;
  assign host_rsp_o = host_rsp_q;
  assign ctrl_rsp_o = ctrl_rsp_q;
  assign input_full_irq_o = in_full_irq_q;
  assign output_drained_irq_o = drained_irq_q;
  assign host_output_empty_irq_o = host_irq_q;
  assign combined_irq_o = comb_irq_q;
  assign idle_o = idle_q;

  //////////////////////////////////////////////////////////////////////////////
  a_in_full_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(input_buffer_full_q) |-> in_full_irq_q && comb_irq_q)
    else $error("input-full interrupt missing");
  a_drained_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(output_buffer_full_q) |-> drained_irq_q && host_irq_q)
    else $error("output-drained interrupt missing");
  a_host_empty_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    host_irq_q |-> !output_buffer_full_q && $past(output_buffer_full_q))
    else $error("host empty interrupt without clear");
  a_combined_or: assert property (@(posedge clk_i) disable iff (!resetn_i)
    comb_irq_q == (in_full_irq_q || drained_irq_q))
    else $error("combined interrupt not the OR");
  a_cmd_flag_tracks: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ibf_set |=> input_buffer_full_q && cmd_flag_q == $past(q_out.is_cmd))
    else $error("command flag wrong after host write");
  a_ibf_clear_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ibf_clr && !ibf_set |=> !input_buffer_full_q)
    else $error("input-buffer-full not cleared by read");
  a_obf_set_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    obf_set |=> output_buffer_full_q ##0 status[`AHEM_ST_OBF_BIT])
    else $error("output-buffer-full not set by write");
  a_byte0_held: assert property (@(posedge clk_i) disable iff (!resetn_i)
    input_buffer_full_q && !ibf_clr |=> $stable(h2c_q[0]))
    else $error("held byte 0 overwritten");
  a_legacy_upper: assert property (@(posedge clk_i) disable iff (!resetn_i)
    host_i.rd && !four && host_i.addr == `AHEM_H_DATA3 |=> host_rsp_o.valid
    && host_rsp_o.data == 8'h00) else $error("upper byte visible in legacy mode");
  a_idle_resume: assert property (@(posedge clk_i) disable iff (!resetn_i)
    any_acc |=> !idle_o) else $error("idle during access");
  a_obf_clear_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    obf_clr && !obf_set |=> !output_buffer_full_q)
    else $error("output-buffer-full not cleared by host read");
  a_mode_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    c_mode_wr |=> four == $past(ctrl_i.wdata[`AHEM_BCTRL_MODE_BIT]))
    else $error("mode bit not taken from byte control write");
  a_cmd_data_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ibf_set && !q_out.is_cmd |=> !cmd_flag_q)
    else $error("command flag left set after data write");
endmodule

////////////////////////////////////////////////////////////////////////////////

module ahem_top
  import ahem_pkg::*;
(
  // Clock and system reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host side port, one per instance, reached by the eSPI host
  input wire ahem_host_req_s [1:0] host_side_port_i,
  output logic [1:0] host_wr_ready_o,
  output ahem_rsp_s [1:0] host_rsp_o,
  output logic [1:0] host_output_empty_irq_o,
  // Controller side port, one per instance, the firmware register path
  input wire ahem_ctrl_req_s [1:0] controller_side_port_i,
  output ahem_rsp_s [1:0] ctrl_rsp_o,
  output logic [1:0] input_full_irq_o,
  output logic [1:0] output_drained_irq_o,
  output logic [1:0] combined_irq_o,
  // Status
  output logic [1:0] idle_o
);
  // No pins of its own; both sides are internal register paths
  // Two independent mailboxes, nothing shared but clock and reset
  for (genvar i = 0; i < 2; i++) begin : g_inst
    ahem_chan u_chan (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .host_i(host_side_port_i[i]),
      .host_wr_ready_o(host_wr_ready_o[i]),
      .host_rsp_o(host_rsp_o[i]),
      .host_output_empty_irq_o(host_output_empty_irq_o[i]),
      .ctrl_i(controller_side_port_i[i]),
      .ctrl_rsp_o(ctrl_rsp_o[i]),
      .input_full_irq_o(input_full_irq_o[i]),
      .output_drained_irq_o(output_drained_irq_o[i]),
      .combined_irq_o(combined_irq_o[i]),
      .idle_o(idle_o[i])
    );
  end
endmodule

`default_nettype wire

// ==== testbench/ahem_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module ahem_partner
  import ahem_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Requests from host and firmware
  output ahem_host_req_s [1:0] host_o,
  output ahem_ctrl_req_s [1:0] ctrl_o,
  // Read answers
  input wire ahem_rsp_s [1:0] host_rsp_i,
  input wire ahem_rsp_s [1:0] ctrl_rsp_i
);
  initial begin
    host_o = '0;
    ctrl_o = '0;
  end

  // Released address and data lines show the inverse, so a stale value never passes
  task automatic hacc(input int i, input logic w, input logic [2:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk_i);
    host_o[i] <= '{w, !w, a, d};
    @(posedge clk_i);
    host_o[i] <= '{1'b0, 1'b0, ~a, ~d};
    #1;
    q = host_rsp_i[i].valid ? host_rsp_i[i].data : 8'hxx;
  endtask

  task automatic cacc(input int i, input logic w, input logic [3:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk_i);
    ctrl_o[i] <= '{w, !w, a, d};
    @(posedge clk_i);
    ctrl_o[i] <= '{1'b0, 1'b0, ~a, ~d};
    #1;
    q = ctrl_rsp_i[i].valid ? ctrl_rsp_i[i].data : 8'hxx;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_ahem_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_ahem_top;
  import ahem_pkg::*;
  logic clk_i;
  logic resetn_i;
  ahem_host_req_s [1:0] hreq;
  ahem_ctrl_req_s [1:0] creq;
  ahem_rsp_s [1:0] hrsp;
  ahem_rsp_s [1:0] crsp;
  logic [1:0] wrdy, hemp, ifull, odr, comb, idle;
  int fail_count;
  int n_compared;
  int nif[2];
  int nod[2];
  int nhe[2];
  int ncb[2];
  logic [7:0] q;
  int k;

  ahem_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .host_side_port_i(hreq),
    .host_wr_ready_o(wrdy), .host_rsp_o(hrsp), .host_output_empty_irq_o(hemp),
    .controller_side_port_i(creq), .ctrl_rsp_o(crsp), .input_full_irq_o(ifull),
    .output_drained_irq_o(odr), .combined_irq_o(comb), .idle_o(idle));
  ahem_partner pm (.clk_i(clk_i), .host_o(hreq), .ctrl_o(creq), .host_rsp_i(hrsp),
    .ctrl_rsp_i(crsp));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Pulse counters sample mid-cycle, away from the edge that launches a pulse;
  // a level stuck high shows up as an excess count
  always @(negedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      nif[i] += int'(ifull[i] === 1'b1);
      nod[i] += int'(odr[i] === 1'b1);
      nhe[i] += int'(hemp[i] === 1'b1);
      ncb[i] += int'(comb[i] === 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      fail_count++;
      $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic clr();
    nif = '{0, 0};
    nod = '{0, 0};
    nhe = '{0, 0};
    ncb = '{0, 0};
  endtask
  task automatic hw(input int i, input logic [2:0] a, input logic [7:0] d);
    pm.hacc(i, 1'b1, a, d, q);
    gap(2);
  endtask
  task automatic hr(input int i, input logic [2:0] a, input logic [7:0] e);
    pm.hacc(i, 1'b0, a, 8'h00, q);
    chk({4'h0, q}, {4'h0, e});
  endtask
  task automatic cw(input int i, input logic [3:0] a, input logic [7:0] d);
    pm.cacc(i, 1'b1, a, d, q);
    gap(2);
  endtask
  task automatic cr(input int i, input logic [3:0] a, input logic [7:0] e);
    pm.cacc(i, 1'b0, a, 8'h00, q);
    chk({4'h0, q}, {4'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  task automatic t_init();
    gap(1);
    chk({wrdy, idle, hemp, ifull, odr, comb}, 12'hf00);
    cr(0, 4'h4, 8'h00);
    cr(1, 4'h5, 8'h00);
    hr(1, 3'h5, 8'h00);
  endtask

  task automatic t_cmd(input int i);
    clr();
    hw(i, 3'h4, 8'ha5);
    chkn(nif[i] + ncb[i] + nif[1-i], 2);
    cr(i, 4'h4, 8'h0a);
    cr(i, 4'h8, 8'ha5);
    cr(i, 4'h4, 8'h08);
    hw(i, 3'h0, 8'h5a);
    cr(i, 4'h4, 8'h02);
    cr(i, 4'h8, 8'h5a);
    cr(i, 4'h4, 8'h00);
  endtask

  task automatic t_obf(input int i);
    clr();
    cw(i, 4'h0, 8'h3c);
    hr(i, 3'h4, 8'h01);
    hr(i, 3'h0, 8'h3c);
    gap(2);
    chkn(nod[i] + nhe[i] + ncb[i] + nod[1-i], 3);
    hr(i, 3'h4, 8'h00);
  endtask

  task automatic t_mode(input int i);
    hw(i, 3'h1, 8'h11);
    cr(i, 4'h9, 8'h00);
    cw(i, 4'h1, 8'h77);
    hr(i, 3'h1, 8'h00);
    cw(i, 4'h5, 8'h01);
    hr(i, 3'h5, 8'h01);
    for (k = 1; k < 4; k++) begin
      hw(i, k[2:0], 8'h20 + k[7:0]);
      cw(i, k[3:0], 8'h40 + k[7:0]);
      cr(i, 4'h8 + k[3:0], 8'h20 + k[7:0]);
      cr(i, k[3:0], 8'h40 + k[7:0]);
      hr(i, k[2:0], 8'h40 + k[7:0]);
    end
    cw(i, 4'h5, 8'h00);
  endtask

  task automatic t_soft(input int i);
    clr();
    cw(i, 4'h4, 8'hff);
    hr(i, 3'h4, 8'hf4);
    chkn(nhe[i] + ncb[i], 0);
    cw(i, 4'h4, 8'h00);
  endtask

  // Firmware stalls while the host fills the queue, then drains it slowly
  task automatic t_fifo(input int i);
    clr();
    k = 0;
    while (wrdy[i] === 1'b1 && k < 40) begin
      pm.hacc(i, 1'b1, 3'h0, k[7:0], q);
      k++;
    end
    chkn(k, 17);
    for (int j = 0; j < 17; j++) begin
      gap(2);
      cr(i, 4'h8, j[7:0]);
    end
    gap(2);
    chkn(nif[i], 17);
    cr(i, 4'h4, 8'h00);
  endtask

  task automatic t_idle();
    gap(3);
    chk({10'h0, idle}, 12'h003);
    pm.hacc(0, 1'b0, 3'h4, 8'h00, q);
    chk({10'h0, idle}, 12'h002);
  endtask

  task automatic t_rst();
    cw(0, 4'h0, 8'h77);
    cw(0, 4'h5, 8'h01);
    resetn_i <= 1'b0;
    gap(3);
    resetn_i <= 1'b1;
    cr(0, 4'h4, 8'h00);
    cr(0, 4'h5, 8'h00);
    hr(0, 3'h0, 8'h00);
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    summarize();
  end

  initial begin
    resetn_i = 1'b0;
    fail_count = 0;
    n_compared = 0;
    gap(16);
    resetn_i <= 1'b1;
    t_init();
    for (int i = 0; i < 2; i++) begin
      t_cmd(i);
      t_obf(i);
      t_mode(i);
      t_soft(i);
    end
    t_fifo(1);
    t_idle();
    t_rst();
    summarize();
  end
endmodule
`default_nettype wire
